// file: acs_pkg.sv
/*
  shared constants, state codes and helpers of the async serial channel.
  assumes: imported by acs_channel and the bench before use; acs_sync2 and acs_buf2 do not use it.
*/
`default_nettype none
package acs_pkg;
  // stop-bit field; zero means the channel is not in async mode
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_ONE_HALF = 2'h2;
  localparam logic [1:0] STOP_TWO = 2'h3;
  // clock factor field and line-clock edges per bit cell
  localparam logic [1:0] FACT_X1 = 2'h0;
  localparam logic [1:0] FACT_X16 = 2'h1;
  localparam logic [1:0] FACT_X32 = 2'h2;
  localparam logic [1:0] FACT_X64 = 2'h3;
  localparam logic [6:0] TICKS_X1 = 7'h01;
  localparam logic [6:0] TICKS_X16 = 7'h10;
  localparam logic [6:0] TICKS_X32 = 7'h20;
  localparam logic [6:0] TICKS_X64 = 7'h40;
  // character length: field value plus the minimum
  localparam logic [3:0] BITS_MIN = 4'h5;
  localparam logic [3:0] BITS_MAX = 4'h8;
  localparam logic [1:0] ENC_NRZ = 2'h0;
  // reset levels of the line outputs
  localparam logic TXD_IDLE = 1'b1;
  localparam logic RTS_N_RST = 1'b1;
  localparam logic DTR_N_RST = 1'b1;
  // positions of the pins in the synchroniser bundle
  localparam int PIN_RXD = 0;
  localparam int PIN_RXC = 1;
  localparam int PIN_TXC = 2;
  localparam int PIN_CTS_N = 3;
  localparam int PIN_DCD_N = 4;
  localparam int PIN_SYNC = 5;
  localparam int PIN_W = 6;
  localparam logic [5:0] PINS_RST = 6'h3F;
  localparam int ENTRY_W = 10;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR = 3'b011, RX_STOP = 3'b100, RX_BREAK = 3'b101
  } acs_rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR = 3'b011, TX_STOP = 3'b100
  } acs_tx_state_t;

  function automatic logic [6:0] acs_ticks(input logic [1:0] f);
    case (f)
      FACT_X1: return TICKS_X1;
      FACT_X16: return TICKS_X16;
      FACT_X32: return TICKS_X32;
      default: return TICKS_X64;
    endcase
  endfunction

  // right-justify t assembled bits, ones above them
  function automatic logic [7:0] acs_fmt(input logic [7:0] sh,
                                         input logic [3:0] t);
    return (sh >> (BITS_MAX - t)) | (8'hFF << t);
  endfunction

  // five-bit mode: leading ones above a zero mark a shorter character
  function automatic logic [3:0] acs_lead(input logic [7:0] d);
    if (!d[7]) return 4'h5;
    if (!d[6]) return 4'h4;
    if (!d[5]) return 4'h3;
    if (!d[4]) return 4'h2;
    return 4'h1;
  endfunction
endpackage
`default_nettype wire

// file: acs_sync2.sv
/*
  two-flop synchroniser for a bundle of pin levels.
  assumes: each bit is a slow level; the bundle is not a word.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acs_sync_st_t;
  acs_sync_st_t st;
  acs_sync_st_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.s2;
endmodule
`default_nettype wire

// file: acs_buf2.sv
/*
  two-entry buffer with valid and ready on both sides.
  assumes: one clock; outputs come from flops.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic v0;
    logic v1;
  } acs_buf_st_t;
  acs_buf_st_t st;
  acs_buf_st_t next_st;

  // pop moves the second entry up, push fills the first free one
  always_comb begin
    next_st = st;
    if (st.v0 && out_ready_in) begin
      next_st.d0 = st.d1;
      next_st.v0 = st.v1;
      next_st.v1 = 1'b0;
    end
    if (in_valid_in && !st.v1) begin
      if (!next_st.v0) begin
        next_st.d0 = in_data_in;
        next_st.v0 = 1'b1;
      end else begin
        next_st.d1 = in_data_in;
        next_st.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready_out = !st.v1;
  assign out_valid_out = st.v0;
  assign out_data_out = st.d0;
endmodule
`default_nettype wire

// file: acs_channel.sv
/*
  async serial channel: receiver, transmitter, modem controls, status.
  assumes: option bits are steady levels on ref_clk_in; pins and the
  line clocks arrive asynchronously and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_channel (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // mode and option bits
  input wire logic [1:0] stop_bits_in,
  input wire logic [1:0] clk_factor_in,
  input wire logic parity_en_in,
  input wire logic parity_even_in,
  input wire logic [1:0] encoding_in,
  input wire logic [1:0] rx_bits_in,
  input wire logic rx_enable_in,
  input wire logic auto_enables_in,
  input wire logic [1:0] tx_bits_in,
  input wire logic tx_enable_in,
  input wire logic send_break_in,
  input wire logic rts_bit_in,
  input wire logic dtr_bit_in,
  input wire logic dtr_is_req_in,
  input wire logic xtal_en_in,
  input wire logic sc_int_en_in,
  input wire logic err_reset_in,
  // line pins
  input wire logic rxd_in,
  input wire logic rx_clk_pin_in,
  input wire logic tx_clk_pin_in,
  input wire logic cts_n_in,
  input wire logic dcd_n_in,
  input wire logic sync_pin_in,
  output logic txd_out,
  output logic rts_n_out,
  output logic dtr_n_out,
  // transmit data
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // receive data
  output logic [7:0] rx_data_out,
  output logic rx_frame_err_out,
  output logic rx_parity_err_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  // status
  output logic rx_break_out,
  output logic rx_parity_latch_out,
  output logic rx_overrun_out,
  output logic special_cond_out,
  output logic sync_hunt_out,
  output logic dcd_out,
  output logic cts_out,
  output logic all_sent_out,
  output logic encoding_fault_out
);
  import acs_pkg::*;

  typedef struct packed {
    acs_rx_state_t rs;
    logic [6:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rpar;
    logic rone;
    logic rxr;
    logic rxc_d;
    logic txc_d;
    acs_tx_state_t ts;
    logic [7:0] tcnt;
    logic [3:0] tbit;
    logic [3:0] tnb;
    logic [7:0] tsh;
    logic tpar;
    logic hold_v;
    logic rdy;
    logic [7:0] hold_d;
    logic tbrk;
    logic tlvl;
    logic txo;
    logic rts_n;
    logic dtr_n;
    logic rbrk;
    logic perr;
    logic ovr;
    logic hunt;
    logic dcd;
    logic cts;
    logic sent;
    logic encf;
    logic spc;
    logic push_v;
    logic [9:0] push_d;
  } acs_chan_st_t;

  acs_chan_st_t st;
  acs_chan_st_t next_st;
  logic [PIN_W-1:0] pins;
  logic buf_ready;
  logic [9:0] buf_data;
  logic buf_valid;
  logic rtick;
  logic ttick;
  logic rsamp;
  logic tedge;
  logic async_on;
  logic rx_on;
  logic tx_on;
  logic [6:0] nt;
  logic [7:0] stop_len;
  logic [3:0] rnb;
  logic [3:0] rt;
  logic rperr;
  logic [3:0] lnb;

  // pins cross into the ref clock domain
  acs_sync2 #(.W(PIN_W), .RST_VAL(PINS_RST)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in({sync_pin_in, dcd_n_in, cts_n_in, tx_clk_pin_in,
           rx_clk_pin_in, rxd_in}),
    .q_out(pins)
  );

  // receive characters wait here; the reader may stall
  acs_buf2 #(.W(ENTRY_W)) u_rxbuf (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .in_valid_in(st.push_v),
    .in_ready_out(buf_ready),
    .in_data_in(st.push_d),
    .out_valid_out(buf_valid),
    .out_ready_in(rx_ready_in),
    .out_data_out(buf_data)
  );

  // next state of the whole channel
  always_comb begin
    next_st = st;
    rtick = pins[PIN_RXC] && !st.rxc_d;
    ttick = pins[PIN_TXC] && !st.txc_d;
    nt = acs_ticks(clk_factor_in);
    async_on = stop_bits_in != STOP_NONE;
    rx_on = async_on && rx_enable_in
            && !(auto_enables_in && pins[PIN_DCD_N]);
    tx_on = async_on && tx_enable_in
            && !(auto_enables_in && pins[PIN_CTS_N]);
    rnb = BITS_MIN + {2'h0, rx_bits_in};
    rt = rnb + {3'h0, parity_en_in && (rnb < BITS_MAX)};
    rsamp = rtick && (st.rcnt == 7'h00);
    tedge = ttick && (st.ts == TX_IDLE || st.tcnt == 8'h00);
    rperr = parity_en_in && (st.rxr ^ st.rpar ^ !parity_even_in);
    lnb = acs_lead(st.hold_d);
    // x1 with one-and-a-half falls back to one cell
    case (stop_bits_in)
      STOP_ONE_HALF: stop_len = {1'b0, nt} + {2'h0, nt[6:1]};
      STOP_TWO: stop_len = {nt, 1'b0};
      default: stop_len = {1'b0, nt};
    endcase
    next_st.rxc_d = pins[PIN_RXC];
    next_st.txc_d = pins[PIN_TXC];
    next_st.push_v = 1'b0;

    // receiver
    if (!rx_on) begin
      next_st.rs = RX_IDLE;
    end else begin
      unique case (st.rs)
        RX_IDLE: begin
          if (rtick && !pins[PIN_RXD]) begin
            next_st.rbit = 4'h0;
            next_st.rone = 1'b0;
            next_st.rxr = 1'b0;
            next_st.rpar = 1'b0;
            next_st.rsh = 8'h00;
            // x1: bits are already aligned outside
            next_st.rs = (nt == TICKS_X1) ? RX_DATA : RX_START;
            next_st.rcnt = (nt == TICKS_X1) ? 7'h00 : (nt >> 1) - 7'h01;
          end
        end
        RX_START: begin
          if (rsamp) begin
            next_st.rs = pins[PIN_RXD] ? RX_IDLE : RX_DATA;
            next_st.rcnt = nt - 7'h01;
          end else if (rtick) begin
            next_st.rcnt = st.rcnt - 7'h01;
          end
        end
        RX_DATA, RX_PAR: begin
          if (rsamp) begin
            next_st.rcnt = nt - 7'h01;
            if (st.rs == RX_DATA || rnb < BITS_MAX) begin
              next_st.rsh = {pins[PIN_RXD], st.rsh[7:1]};
            end
            if (st.rs == RX_PAR) begin
              next_st.rpar = pins[PIN_RXD];
              next_st.rs = RX_STOP;
            end else begin
              next_st.rone = st.rone | pins[PIN_RXD];
              next_st.rxr = st.rxr ^ pins[PIN_RXD];
              next_st.rbit = st.rbit + 4'h1;
              if (st.rbit + 4'h1 == rnb) begin
                next_st.rs = parity_en_in ? RX_PAR : RX_STOP;
              end
            end
          end else if (rtick) begin
            next_st.rcnt = st.rcnt - 7'h01;
          end
        end
        RX_STOP: begin
          if (rsamp) begin
            next_st.rs = RX_IDLE;
            if (!pins[PIN_RXD] && !st.rone) begin
              next_st.rbrk = 1'b1;
              next_st.rs = RX_BREAK;
            end else begin
              next_st.push_v = 1'b1;
              // framing error sampled once, stored with data
              next_st.push_d = {rperr, !pins[PIN_RXD],
                                acs_fmt(st.rsh, rt)};
            end
          end else if (rtick) begin
            next_st.rcnt = st.rcnt - 7'h01;
          end
        end
        RX_BREAK: begin
          if (pins[PIN_RXD]) begin
            next_st.rbrk = 1'b0;
            next_st.rs = RX_IDLE;
            next_st.push_v = 1'b1;
            // the left-over null
            next_st.push_d = {parity_en_in && !parity_even_in, 1'b0,
                              acs_fmt(8'h00, rt)};
          end
        end
        default: next_st.rs = RX_IDLE;
      endcase
    end

    // error flags: a set in the clearing cycle wins
    if (err_reset_in) begin
      next_st.perr = 1'b0;
      next_st.ovr = 1'b0;
    end
    if (st.push_v && st.push_d[9]) begin
      next_st.perr = 1'b1;
    end
    if (st.push_v && !buf_ready) begin
      next_st.ovr = 1'b1;
    end
    next_st.spc = buf_valid && (buf_data[8]
                  || (st.perr && sc_int_en_in));

    // transmit holding register
    if (tx_valid_in && !st.hold_v) begin
      next_st.hold_v = 1'b1;
      next_st.hold_d = tx_data_in;
    end

    // break follows the bit at cell boundaries only
    if (tedge) begin
      next_st.tbrk = send_break_in;
    end

    // transmitter
    if (!async_on) begin
      next_st.ts = TX_IDLE;
      next_st.tlvl = TXD_IDLE;
    end else if (ttick) begin
      unique case (st.ts)
        TX_IDLE: begin
        end
        TX_START, TX_DATA: begin
          if (st.tcnt == 8'h00) begin
            next_st.tcnt = {1'b0, nt} - 8'h01;
            if (st.ts == TX_DATA && st.tbit == st.tnb) begin
              next_st.ts = parity_en_in ? TX_PAR : TX_STOP;
              next_st.tlvl = parity_en_in ? st.tpar : 1'b1;
              if (!parity_en_in) begin
                next_st.tcnt = stop_len - 8'h01;
              end
            end else begin
              next_st.ts = TX_DATA;
              next_st.tlvl = st.tsh[0];
              next_st.tsh = {1'b1, st.tsh[7:1]};
              next_st.tbit = st.tbit + 4'h1;
            end
          end else begin
            next_st.tcnt = st.tcnt - 8'h01;
          end
        end
        TX_PAR: begin
          if (st.tcnt == 8'h00) begin
            next_st.ts = TX_STOP;
            next_st.tlvl = 1'b1;
            next_st.tcnt = stop_len - 8'h01;
          end else begin
            next_st.tcnt = st.tcnt - 8'h01;
          end
        end
        TX_STOP: begin
          if (st.tcnt == 8'h00) begin
            next_st.ts = TX_IDLE;
          end else begin
            next_st.tcnt = st.tcnt - 8'h01;
          end
        end
        default: next_st.ts = TX_IDLE;
      endcase
      // a new character starts on a cell boundary, back to back allowed
      if (tedge && (st.ts == TX_IDLE || st.ts == TX_STOP)
          && st.hold_v && tx_on) begin
        next_st.ts = TX_START;
        next_st.tlvl = 1'b0;
        next_st.tcnt = {1'b0, nt} - 8'h01;
        next_st.tbit = 4'h0;
        next_st.tsh = st.hold_d;
        next_st.hold_v = 1'b0;
        next_st.tnb = (tx_bits_in == 2'h0) ? lnb
                      : BITS_MIN + {2'h0, tx_bits_in};
        next_st.tpar = ^(st.hold_d & ~(8'hFF << next_st.tnb))
                       ^ !parity_even_in;
      end
    end
    next_st.txo = next_st.tlvl && !next_st.tbrk;

    // status and modem lines
    next_st.sent = (next_st.ts == TX_IDLE) && !next_st.hold_v;
    next_st.rdy = !next_st.hold_v;
    next_st.rts_n = rts_bit_in ? 1'b0
                    : (auto_enables_in ? (st.rts_n | next_st.sent)
                       : 1'b1);
    next_st.dtr_n = dtr_is_req_in ? DTR_N_RST : !dtr_bit_in;
    next_st.hunt = xtal_en_in ? 1'b0 : pins[PIN_SYNC];
    next_st.dcd = !pins[PIN_DCD_N];
    next_st.cts = !pins[PIN_CTS_N];
    next_st.encf = (encoding_in != ENC_NRZ)
                   && (clk_factor_in != FACT_X1);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
      st.tlvl <= TXD_IDLE;
      st.txo <= TXD_IDLE;
      st.rts_n <= RTS_N_RST;
      st.dtr_n <= DTR_N_RST;
      st.sent <= 1'b1;
      st.rdy <= 1'b1;
      // edge detectors start at the synced clocks' reset level: no false tick
      st.rxc_d <= PINS_RST[PIN_RXC];
      st.txc_d <= PINS_RST[PIN_TXC];
    end else begin
      st <= next_st;
    end
  end

  // outputs, each from a flop
  assign txd_out = st.txo;
  assign rts_n_out = st.rts_n;
  assign dtr_n_out = st.dtr_n;
  assign tx_ready_out = st.rdy;
  assign rx_data_out = buf_data[7:0];
  assign rx_frame_err_out = buf_data[8];
  assign rx_parity_err_out = buf_data[9];
  assign rx_valid_out = buf_valid;
  assign rx_break_out = st.rbrk;
  assign rx_parity_latch_out = st.perr;
  assign rx_overrun_out = st.ovr;
  assign special_cond_out = st.spc;
  assign sync_hunt_out = st.hunt;
  assign dcd_out = st.dcd;
  assign cts_out = st.cts;
  assign all_sent_out = st.sent;
  assign encoding_fault_out = st.encf;

  // checks on the channel's own behaviour
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_stop_low;
    st.rs == RX_STOP && rx_on && rsamp && !pins[PIN_RXD];
  endsequence
  sequence s_break_end;
    st.rs == RX_BREAK && rx_on && pins[PIN_RXD];
  endsequence

  async_gate_a: assert property (
    stop_bits_in == STOP_NONE |=> st.rs == RX_IDLE && st.ts == TX_IDLE)
    else $error("channel active outside async mode");
  frame_flag_a: assert property (
    s_stop_low and st.rone |=> st.push_v && st.push_d[8])
    else $error("framing error not stored");
  break_set_a: assert property (
    s_stop_low and !st.rone |=> st.rbrk && !st.push_v ##1 !st.push_v)
    else $error("break not recognised");
  break_end_a: assert property (
    s_break_end |=> st.push_v && !st.push_d[8] && !st.rbrk
    && st.push_d[9] == ($past(parity_en_in) && !$past(parity_even_in)))
    else $error("break end null wrong");
  parity_hold_a: assert property (
    rx_parity_latch_out && !err_reset_in |=> rx_parity_latch_out)
    else $error("parity error flag lost");
  dtr_pin_a: assert property (
    !dtr_is_req_in |=> dtr_n_out == !$past(dtr_bit_in))
    else $error("dtr pin wrong");
  hunt_force_a: assert property (
    xtal_en_in ##1 xtal_en_in |-> !sync_hunt_out)
    else $error("sync/hunt not forced low");
  rts_on_a: assert property (
    rts_bit_in |=> !rts_n_out)
    else $error("rts pin not low");
  rts_hold_a: assert property (
    (auto_enables_in && !rts_bit_in && !rts_n_out) ##1 !all_sent_out
    |-> !rts_n_out)
    else $error("rts released before all sent");
  break_line_a: assert property (
    st.tbrk |-> !txd_out)
    else $error("break not driving zero");
  cts_gate_a: assert property (
    st.ts == TX_IDLE && auto_enables_in && pins[PIN_CTS_N]
    |=> st.ts == TX_IDLE)
    else $error("transmitter started with cts high");
  dcd_gate_a: assert property (
    auto_enables_in && pins[PIN_DCD_N] |=> st.rs == RX_IDLE)
    else $error("receiver running with dcd high");
  all_sent_a: assert property (
    all_sent_out |-> st.ts == TX_IDLE && (txd_out || st.tbrk))
    else $error("all sent while busy");
endmodule
`default_nettype wire

// file: acs_far_end.sv
/* far-end serial device: bit clock, character sender and catcher.
   assumes: x1 clock factor; the channel samples on rising edges. */
`timescale 1ns/10ps
`default_nettype none
module acs_far_end (
  // line side
  output var logic line_clk_out,
  output var logic rxd_out,
  input wire logic txd_in
);
  // idle line is mark
  initial begin
    line_clk_out = 1'b0;
    rxd_out = 1'b1;
  end
  // free-running bit clock, sixteen system cycles
  always #200 line_clk_out = ~line_clk_out;
  // send n cells lsb first on falling edges, then back to mark
  task automatic send(input logic [11:0] cells, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge line_clk_out) rxd_out = cells[i];
    end
    @(negedge line_clk_out) rxd_out = 1'b1;
  endtask
  // catch n cells from the start bit on, mid-cell
  task automatic catch(output logic [11:0] cells, input int n);
    cells = 12'hFFF;
    @(negedge txd_in);
    for (int i = 0; i < n; i++) begin
      @(negedge line_clk_out) cells[i] = txd_in;
    end
  endtask
endmodule
`default_nettype wire

// file: async_serial_channel_test.sv
/* bench of the async serial channel against a far-end model.
   assumes: acs_pkg, acs_channel and acs_far_end compiled first. */
`timescale 1ns/10ps
`default_nettype none
module async_serial_channel_test;
  import acs_pkg::*;
  // drives, all settled at time zero
  logic ref_clk_in = 1'b0, rst_in = 1'b1, parity_en_in = 1'b0;
  logic parity_even_in = 1'b0, rx_enable_in = 1'b0, tx_enable_in = 1'b0;
  logic auto_enables_in = 1'b0, send_break_in = 1'b0, rts_bit_in = 1'b0;
  logic dtr_bit_in = 1'b0, dtr_is_req_in = 1'b0, xtal_en_in = 1'b0;
  logic sc_int_en_in = 1'b0, err_reset_in = 1'b0, cts_n_in = 1'b0;
  logic dcd_n_in = 1'b0, sync_pin_in = 1'b0, tx_valid_in = 1'b0;
  logic rx_ready_in = 1'b0;
  logic [1:0] stop_bits_in = STOP_ONE;
  logic [1:0] clk_factor_in = FACT_X1;
  logic [1:0] encoding_in = ENC_NRZ, rx_bits_in = 2'h3, tx_bits_in = 2'h3;
  logic [7:0] tx_data_in = 8'h00;
  wire logic rxd_in, rx_clk_pin_in, tx_clk_pin_in;
  // channel outputs
  logic txd_out, rts_n_out, dtr_n_out, tx_ready_out, rx_frame_err_out;
  logic rx_parity_err_out, rx_valid_out, rx_break_out, rx_parity_latch_out;
  logic rx_overrun_out, special_cond_out, sync_hunt_out, dcd_out, cts_out;
  logic all_sent_out, encoding_fault_out;
  logic [7:0] rx_data_out;
  int failures = 0, comparisons = 0;

  acs_channel u_acs_channel (.*);
  acs_far_end u_acs_far_end (.line_clk_out(rx_clk_pin_in),
    .rxd_out(rxd_in), .txd_in(txd_out));
  // one bit clock for both directions
  assign tx_clk_pin_in = rx_clk_pin_in;
  always #12.5 ref_clk_in = ~ref_clk_in;

  // parity over the low b bits
  function automatic logic par(input logic [7:0] d, input int b);
    return ^(d & ~(8'hFF << b)) ^ ~parity_even_in;
  endfunction
  // line cells: start, data lsb first, parity, stop
  function automatic logic [11:0] frm(input logic [7:0] d, input int b,
                                      input logic stop);
    logic [11:0] c;
    c = 12'hFFE;
    for (int i = 0; i < b; i++)
      c[i+1] = d[i];
    if (parity_en_in)
      c[b+1] = par(d, b);
    c[b+1+int'(parity_en_in)] = stop;
    return c;
  endfunction
  // received byte: data, parity above, ones above that
  function automatic logic [7:0] rexp(input logic [7:0] d, input int b);
    return (d & ~(8'hFF << b)) | (8'(par(d, b)) << b)
      | (8'hFF << (b + int'(parity_en_in)));
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  // take the head: {condition, 0, frame, parity, data}
  task automatic pop(output logic [11:0] got);
    // look only at settled outputs, never in the launching time step
    @(negedge ref_clk_in);
    for (int n = 0; n < 400 && rx_valid_out !== 1'b1; n++)
      @(negedge ref_clk_in);
    got[9:0] = {rx_frame_err_out, rx_parity_err_out, rx_data_out};
    @(posedge ref_clk_in) rx_ready_in <= 1'b1;
    @(negedge ref_clk_in) got[11:10] = {special_cond_out, 1'b0};
    @(posedge ref_clk_in) rx_ready_in <= 1'b0;
  endtask
  task automatic err_rst;
    @(posedge ref_clk_in) err_reset_in <= 1'b1;
    @(posedge ref_clk_in) err_reset_in <= 1'b0;
    tick(2);
    chk(12'({rx_parity_latch_out, special_cond_out}), 12'h0);
  endtask
  // every length with parity, then a bad stop bit
  task automatic t_rx;
    logic [11:0] got;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_in);
      rx_bits_in <= 2'(k);
      parity_even_in <= k[0];
      parity_en_in <= 1'b1;
      @(posedge ref_clk_in);
      d = 8'hA5 ^ 8'(k);
      u_acs_far_end.send(frm(d, 5 + k, 1'b1), 8 + k);
      pop(got);
      chk(got, {4'h0, rexp(d, 5 + k)});
    end
    u_acs_far_end.send(frm(8'h3C, 8, 1'b0), 11);
    pop(got);
    chk(got, 12'hA3C);
    $display("test rx finished");
  endtask
  // parity latch, condition enable and break
  task automatic t_err;
    logic [11:0] got;
    @(posedge ref_clk_in);
    parity_even_in <= 1'b0;
    sc_int_en_in <= 1'b1;
    @(posedge ref_clk_in);
    u_acs_far_end.send(frm(8'h3C, 8, 1'b1) ^ 12'h200, 11);
    pop(got);
    chk(got, 12'h93C);
    tick(3);
    // flag stays latched; the condition needs a character at the head
    chk(12'({rx_parity_latch_out, special_cond_out}), 12'h2);
    err_rst();
    @(posedge ref_clk_in) sc_int_en_in <= 1'b0;
    u_acs_far_end.send(12'h000, 12);
    chk(12'(rx_break_out), 12'h1);
    pop(got);
    chk(got, 12'h100);
    chk(12'({rx_break_out, rx_parity_latch_out}), 12'h1);
    err_rst();
    $display("test errors finished");
  endtask
  // three characters with no reader: the third is dropped
  task automatic t_ovr;
    logic [11:0] got;
    for (int i = 0; i < 3; i++)
      u_acs_far_end.send(frm(8'h11 << i, 8, 1'b1), 11);
    chk(12'({rx_overrun_out, tx_ready_out}), 12'h3);
    pop(got);
    chk(got, 12'h011);
    pop(got);
    chk(got, 12'h022);
    err_rst();
    chk(12'(rx_overrun_out), 12'h0);
    $display("test overrun finished");
  endtask
  // one character out, caught on the line, then all sent
  task automatic tx_one(input logic [7:0] d, input int b, input int n);
    logic [11:0] got;
    fork
      u_acs_far_end.catch(got, n);
      begin
        @(posedge ref_clk_in);
        tx_data_in <= d;
        tx_valid_in <= 1'b1;
        @(posedge ref_clk_in) tx_valid_in <= 1'b0;
      end
    join
    chk(got, frm(d, b, 1'b1));
    chk(12'(all_sent_out), 12'h0);
    for (int i = 0; i < 100 && all_sent_out !== 1'b1; i++)
      @(negedge ref_clk_in);
    chk(12'(all_sent_out), 12'h1);
  endtask
  task automatic t_tx;
    tx_one(8'h96, 8, 11);
    @(posedge ref_clk_in) tx_bits_in <= 2'h0;
    tx_one(8'hE2, 2, 5);
    tx_one(8'h00, 5, 8);
    @(posedge ref_clk_in) send_break_in <= 1'b1;
    tick(40);
    chk(12'(txd_out), 12'h0);
    @(posedge ref_clk_in) send_break_in <= 1'b0;
    tick(40);
    chk(12'(txd_out), 12'h1);
    $display("test tx finished");
  endtask
  // modem lines, encoding check, auto enables
  task automatic t_modem;
    logic [11:0] got;
    @(posedge ref_clk_in);
    rts_bit_in <= 1'b1;
    dtr_bit_in <= 1'b1;
    sync_pin_in <= 1'b1;
    cts_n_in <= 1'b1;
    tick(4);
    chk(12'({rts_n_out, dtr_n_out}), 12'h0);
    chk(12'({sync_hunt_out, cts_out}), 12'h2);
    @(posedge ref_clk_in);
    dtr_is_req_in <= 1'b1;
    xtal_en_in <= 1'b1;
    cts_n_in <= 1'b0;
    clk_factor_in <= FACT_X16;
    encoding_in <= 2'h1;
    tick(4);
    chk(12'({dtr_n_out, sync_hunt_out}), 12'h2);
    chk(12'({cts_out, encoding_fault_out}), 12'h3);
    @(posedge ref_clk_in);
    clk_factor_in <= FACT_X1;
    auto_enables_in <= 1'b1;
    dcd_n_in <= 1'b1;
    tick(4);
    chk(12'({dcd_out, encoding_fault_out}), 12'h0);
    u_acs_far_end.send(frm(8'h55, 8, 1'b1), 11);
    tick(20);
    chk(12'(rx_valid_out), 12'h0);
    // cts high holds a waiting character; rts stays low until all sent
    @(posedge ref_clk_in) cts_n_in <= 1'b1;
    tick(4);
    @(posedge ref_clk_in);
    rts_bit_in <= 1'b0;
    tx_data_in <= 8'h0A;
    tx_valid_in <= 1'b1;
    @(posedge ref_clk_in) tx_valid_in <= 1'b0;
    tick(40);
    chk(12'({txd_out, tx_ready_out, rts_n_out}), 12'h4);
    fork
      u_acs_far_end.catch(got, 8);
      @(posedge ref_clk_in) cts_n_in <= 1'b0;
    join
    chk(got, frm(8'h0A, 5, 1'b1));
    chk(12'(rts_n_out), 12'h0);
    tick(20);
    chk(12'(rts_n_out), 12'h1);
    $display("test modem finished");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset, then enables after the options, then the tests
  initial begin
    repeat (6) @(negedge ref_clk_in);
    chk(12'({txd_out, rts_n_out, dtr_n_out, all_sent_out}), 12'hF);
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rx_enable_in <= 1'b1;
    tx_enable_in <= 1'b1;
    t_rx();
    t_err();
    t_ovr();
    t_tx();
    t_modem();
    wrap_up();
  end
  // cuts a hang short
  initial begin
    #1ms;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
